// *** common/asp_pkg.sv ***
// Shared constants, types and helpers of the audio serial port
package asp_pkg;

  // ==========================================================
  // Word and frame geometry
  localparam int ASP_WORD_W = 16;
  localparam int ASP_SHORT_W = 8;
  localparam int ASP_BIT_W = 4;
  localparam int ASP_SLOT_W = 2;
  localparam int ASP_MAX_SLOTS = 4;
  localparam logic [3:0] ASP_LAST_BIT_16 = 4'hf;
  localparam logic [3:0] ASP_LAST_BIT_8 = 4'h7;

  // ==========================================================
  // Buffering and crossing
  localparam int ASP_FIFO_DEPTH = 8;
  localparam int ASP_CFG_W = 5;
  localparam logic [ASP_CFG_W-1:0] ASP_CFG_RST = 5'h00;
  localparam logic [15:0] ASP_WORD_RST = 16'h0000;

  // ==========================================================
  // Frame state of each link path
  typedef enum logic {
    ASP_IDLE,
    ASP_ACTIVE
  } asp_frame_t;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] asp_last_bit(input logic w16);
    asp_last_bit = w16 ? ASP_LAST_BIT_16 : ASP_LAST_BIT_8;
  endfunction : asp_last_bit

  function automatic logic [1:0] asp_last_slot(
    input logic net,
    input logic [1:0] slots_m1
  );
    asp_last_slot = net ? slots_m1 : 2'h0;
  endfunction : asp_last_slot

endpackage : asp_pkg

// *** design/asp_fifo.sv ***
// Word FIFO with valid/ready on both sides and a registered output
`timescale 1ns/10ps

module asp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Elaboration check
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_param
    $error("asp_fifo: DEPTH must be a power of two >= 2");
  end

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic [WIDTH-1:0] out_q;
  logic out_v_q;

  wire full = (cnt_q == (AW+1)'(DEPTH));
  wire empty = (cnt_q == '0);
  wire push = in_valid & ~full;
  // Output stage refills when it empties or is taken
  wire pop = ~empty & (~out_v_q | out_ready);

  assign in_ready = ~full;
  assign out_valid = out_v_q;
  assign out_data = out_q;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_q <= '0;
      out_v_q <= 1'b0;
    end
    else if (pop)
    begin
      out_q <= mem_q[rd_q];
      out_v_q <= 1'b1;
    end
    else if (out_ready)
    begin
      out_v_q <= 1'b0;
    end
  end

endmodule : asp_fifo

// *** design/asp_port.sv ***
// Audio serial port: full-duplex slave link with word FIFOs
`timescale 1ns/10ps

// ============================================================
// Notes on behaviour
// R1 - Transmit and receive run at the same time over a synchronous link.
// R2 - Each path has its own logic, and its own clock in the asynchronous setting; neither waits on the other.
// R3 - Each direction uses shift clock, frame sync and one data line.
// R4 - Asynchronous setting: each direction has its own clock and sync.
// R5 - Synchronous setting: both directions use the transmit clock and sync.
// R6 - Word length is 8 or 16 bits; all words share the length.
// R7 - At most four slots per frame.
// R8 - Normal mode moves one word per frame.
// R9 - Network mode moves one word per slot, several per frame.
// R10 - Frame sync starts a frame and restarts slot counting at slot zero.
// R11 - Separate DMA requests for receive data and transmit data.
// R12 - Slave only: clock and frame sync always come from the far end.
// R13 - MSB first; slot zero's first bit aligns with frame sync.

module asp_port #(
  parameter int FIFO_DEPTH = asp_pkg::ASP_FIFO_DEPTH
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_sclk,
  input wire logic rx_sclk,
  // Configuration, ref_clk domain
  input wire logic cfg_enable,
  input wire logic cfg_sync_mode,
  input wire logic cfg_network,
  input wire logic cfg_word16,
  input wire logic [asp_pkg::ASP_SLOT_W-1:0] cfg_slots_m1,
  // Transmit link pins
  input wire logic tx_fs,
  output logic tx_sd_o,
  output logic tx_sd_oe_n,
  // Receive link pins
  input wire logic rx_fs,
  input wire logic rx_sd,
  // Transmit words and request
  input wire logic [asp_pkg::ASP_WORD_W-1:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_dma_req,
  // Receive words and request
  output logic [asp_pkg::ASP_WORD_W-1:0] rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_dma_req,
  output logic rx_overrun
);

  import asp_pkg::*;

  // ==========================================================
  // Elaboration check
  if (FIFO_DEPTH < 2)
  begin : g_bad_depth
    $error("asp_port: FIFO_DEPTH must be at least 2");
  end

  // ==========================================================
  // Link clock and sync selection
  // Glitch hazard: change cfg_sync_mode only while disabled
  wire rx_clk = cfg_sync_mode ? tx_sclk : rx_sclk; // R5 R4
  wire r_fs = cfg_sync_mode ? tx_fs : rx_fs; // R5 R4
  wire [ASP_CFG_W-1:0] cfg_bus = {
    cfg_enable, cfg_network, cfg_word16, cfg_slots_m1
  };

  // ==========================================================
  // Transmit side, ref_clk domain
  logic [ASP_WORD_W-1:0] txf_data;
  logic txf_valid;
  logic [ASP_WORD_W-1:0] tx_hold_q;
  logic treq_q;
  logic tack1_q;
  logic tack2_q;
  logic tack_q;

  // Word is in flight until the link echoes the toggle
  wire t_pending = treq_q ^ tack2_q;
  wire t_take = txf_valid & ~t_pending;

  asp_fifo #(
    .WIDTH(ASP_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_data(tx_word),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(txf_data),
    .out_valid(txf_valid),
    .out_ready(~t_pending)
  );

  assign tx_dma_req = tx_ready; // R11

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_hold_q <= ASP_WORD_RST;
      treq_q <= 1'b0;
      tack1_q <= 1'b0;
      tack2_q <= 1'b0;
    end
    else
    begin
      tack1_q <= tack_q;
      tack2_q <= tack1_q;
      if (t_take)
      begin
        tx_hold_q <= txf_data;
        treq_q <= ~treq_q;
      end
    end
  end

  // ==========================================================
  // Transmit side, tx_sclk domain
  logic [ASP_CFG_W-1:0] tcfg1_q;
  logic [ASP_CFG_W-1:0] tcfg2_q;
  logic treq1_q;
  logic treq2_q;
  asp_frame_t tstate_q;
  logic [ASP_BIT_W-1:0] tbit_q;
  logic [ASP_SLOT_W-1:0] tslot_q;
  logic [ASP_WORD_W-1:0] tsh_q;
  logic tdrv_q;

  wire t_en = tcfg2_q[4];
  wire t_w16 = tcfg2_q[2];
  wire [1:0] t_last_slot = asp_last_slot(tcfg2_q[3], tcfg2_q[1:0]); // R7
  wire t_last_bit = (tbit_q == asp_last_bit(t_w16)); // R6
  wire t_word_end = (tstate_q == ASP_ACTIVE) & t_last_bit;
  wire t_more = t_word_end & (tslot_q != t_last_slot); // R9 R8
  wire t_start = t_en & (tx_fs | t_more); // R10 R12
  wire t_avail = treq2_q ^ tack_q;
  wire t_load = t_start & t_avail;
  // Left-align so the MSB is always at the top
  wire [ASP_WORD_W-1:0] t_fill = t_w16 ? tx_hold_q
                                       : {tx_hold_q[7:0], 8'h00};

  always_ff @(posedge tx_sclk or posedge rst)
  begin
    if (rst)
    begin
      tcfg1_q <= ASP_CFG_RST;
      tcfg2_q <= ASP_CFG_RST;
      treq1_q <= 1'b0;
      treq2_q <= 1'b0;
    end
    else
    begin
      tcfg1_q <= cfg_bus;
      tcfg2_q <= tcfg1_q;
      treq1_q <= treq_q;
      treq2_q <= treq1_q;
    end
  end

  always_ff @(posedge tx_sclk or posedge rst)
  begin
    if (rst)
    begin
      tack_q <= 1'b0;
    end
    else if (t_load)
    begin
      tack_q <= ~tack_q;
    end
  end

  always_ff @(posedge tx_sclk or posedge rst)
  begin
    if (rst)
    begin
      tstate_q <= ASP_IDLE;
      tbit_q <= '0;
      tslot_q <= '0;
      tsh_q <= ASP_WORD_RST;
      tdrv_q <= 1'b0;
    end
    else if (!t_en)
    begin
      tstate_q <= ASP_IDLE;
      tdrv_q <= 1'b0;
    end
    else if (t_start)
    begin
      tstate_q <= ASP_ACTIVE;
      tbit_q <= '0;
      tslot_q <= tx_fs ? 2'h0 : tslot_q + 2'h1; // R10
      tsh_q <= t_load ? t_fill : ASP_WORD_RST; // R13
      tdrv_q <= t_load;
    end
    else if (t_word_end)
    begin
      tstate_q <= ASP_IDLE;
      tdrv_q <= 1'b0;
    end
    else if (tstate_q == ASP_ACTIVE)
    begin
      tbit_q <= tbit_q + 4'h1;
      tsh_q <= {tsh_q[14:0], 1'b0}; // R13
    end
  end

  // Empty slots are left undriven for other talkers
  assign tx_sd_o = tsh_q[15]; // R3
  assign tx_sd_oe_n = ~tdrv_q;

  // ==========================================================
  // Receive side, link clock domain
  logic [ASP_CFG_W-1:0] rcfg1_q;
  logic [ASP_CFG_W-1:0] rcfg2_q;
  asp_frame_t rstate_q;
  logic [ASP_BIT_W-1:0] rbit_q;
  logic [ASP_SLOT_W-1:0] rslot_q;
  logic [ASP_WORD_W-1:0] rsh_q;
  logic [ASP_WORD_W-1:0] rword_q;
  logic rtgl_q;

  wire r_en = rcfg2_q[4];
  wire r_w16 = rcfg2_q[2];
  wire [1:0] r_last_slot = asp_last_slot(rcfg2_q[3], rcfg2_q[1:0]); // R7
  wire r_last_bit = (rbit_q == asp_last_bit(r_w16)); // R6
  wire r_active = (rstate_q == ASP_ACTIVE);
  wire [ASP_WORD_W-1:0] r_sh_in = {rsh_q[14:0], rx_sd}; // R13
  wire r_done = r_en & r_active & ~r_fs & r_last_bit;

  always_ff @(posedge rx_clk or posedge rst)
  begin
    if (rst)
    begin
      rcfg1_q <= ASP_CFG_RST;
      rcfg2_q <= ASP_CFG_RST;
    end
    else
    begin
      rcfg1_q <= cfg_bus;
      rcfg2_q <= rcfg1_q;
    end
  end

  always_ff @(posedge rx_clk or posedge rst)
  begin
    if (rst)
    begin
      rstate_q <= ASP_IDLE;
      rbit_q <= '0;
      rslot_q <= '0;
      rsh_q <= ASP_WORD_RST;
    end
    else if (!r_en)
    begin
      rstate_q <= ASP_IDLE;
    end
    else if (r_fs)
    begin
      rstate_q <= ASP_ACTIVE; // R10 R12
      rbit_q <= 4'h1;
      rslot_q <= '0;
      rsh_q <= r_sh_in;
    end
    else if (r_active)
    begin
      rsh_q <= r_sh_in;
      rbit_q <= r_last_bit ? 4'h0 : rbit_q + 4'h1;
      if (r_last_bit)
      begin
        rslot_q <= rslot_q + 2'h1;
        if (rslot_q == r_last_slot)
        begin
          rstate_q <= ASP_IDLE; // R8 R9
        end
      end
    end
  end

  // Word stays put for a whole word time, ample for the crossing
  always_ff @(posedge rx_clk or posedge rst)
  begin
    if (rst)
    begin
      rword_q <= ASP_WORD_RST;
      rtgl_q <= 1'b0;
    end
    else if (r_done)
    begin
      rword_q <= r_w16 ? r_sh_in : {8'h00, r_sh_in[7:0]}; // R6
      rtgl_q <= ~rtgl_q;
    end
  end

  // ==========================================================
  // Receive side, ref_clk domain
  logic rt1_q;
  logic rt2_q;
  logic rt3_q;
  logic rx_ovr_q;
  logic rxf_in_ready;

  wire r_new = rt2_q ^ rt3_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rt1_q <= 1'b0;
      rt2_q <= 1'b0;
      rt3_q <= 1'b0;
      rx_ovr_q <= 1'b0;
    end
    else
    begin
      rt1_q <= rtgl_q;
      rt2_q <= rt1_q;
      rt3_q <= rt2_q;
      // A word with no room is lost and flagged
      rx_ovr_q <= r_new & ~rxf_in_ready;
    end
  end

  asp_fifo #(
    .WIDTH(ASP_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_data(rword_q),
    .in_valid(r_new),
    .in_ready(rxf_in_ready),
    .out_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign rx_dma_req = rx_valid; // R11 R1 R2
  assign rx_overrun = rx_ovr_q;

endmodule : asp_port

// *** verification/asp_port_properties.sv ***
// Port-level properties of the audio serial port
`timescale 1ns/10ps

module asp_port_properties (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_sclk,
  // Configuration and link
  input wire logic cfg_network,
  input wire logic cfg_word16,
  input wire logic tx_fs,
  input wire logic tx_sd_oe_n,
  // Word sides
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_dma_req,
  input wire logic [asp_pkg::ASP_WORD_W-1:0] rx_word,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_dma_req,
  input wire logic rx_overrun
);
  import asp_pkg::*;

  // ==========================================================
  // Word side
  tx_req_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_dma_req == tx_ready) else $error("tx request differs from ready");
  rx_req_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    rx_dma_req == rx_valid) else $error("rx request differs from valid");
  rx_word_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_word)) else $error("rx word dropped");
  tx_ready_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    !tx_valid && tx_ready |=> tx_ready) else $error("tx ready fell without a push");
  tx_full_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(tx_ready) |-> $past(tx_valid)) else $error("tx full without a write");
  byte_zero_ext_a: assert property (@(posedge ref_clk) disable iff (rst)
    rx_valid && !cfg_word16 |-> rx_word[15:8] == 8'h00) else $error("8-bit word not extended");

  // ==========================================================
  // Transmit link
  frame_start_a: assert property (@(posedge tx_sclk) disable iff (rst)
    $fell(tx_sd_oe_n) && !cfg_network |-> $past(tx_fs)) else $error("drive began off sync");
  byte_length_a: assert property (@(posedge tx_sclk) disable iff (rst)
    $fell(tx_sd_oe_n) && !cfg_network && !cfg_word16 |-> !tx_sd_oe_n[*8] ##1 tx_sd_oe_n)
    else $error("8-bit word not 8 bits long");

  cover property (@(posedge ref_clk) rx_overrun);
  cover property (@(posedge ref_clk) !tx_ready);
  cover property (@(posedge tx_sclk) $fell(tx_sd_oe_n) && cfg_network);
endmodule : asp_port_properties

bind asp_port asp_port_properties i_asp_port_properties (
  .ref_clk(ref_clk), .rst(rst), .tx_sclk(tx_sclk), .cfg_network(cfg_network),
  .cfg_word16(cfg_word16), .tx_fs(tx_fs), .tx_sd_oe_n(tx_sd_oe_n), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_dma_req(tx_dma_req), .rx_word(rx_word), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_dma_req(rx_dma_req), .rx_overrun(rx_overrun));

// *** verification/asp_far_end.sv ***
// Far-end codec model: link clocks, frame syncs, receive data, transmit capture
`timescale 1ns/10ps

module asp_far_end (
  // Link clocks and syncs
  output logic tx_sclk,
  output logic rx_sclk,
  output logic tx_fs,
  output logic rx_fs,
  // Data lines
  output logic rx_sd,
  input wire logic tx_sd_o,
  input wire logic tx_sd_oe_n
);
  logic [1:0] clk_q = 2'b00;
  logic [1:0] fs_q = 2'b00;
  logic [63:0] got;
  int nbits;

  assign tx_sclk = clk_q[0];
  assign rx_sclk = clk_q[1];
  assign tx_fs = fs_q[0];
  assign rx_fs = fs_q[1];
  initial rx_sd = 1'b0;

  // ==========================================================
  // One lane; clock runs from six cycles before sync to two after the data, then stands still
  task automatic lane(input bit rxl, input bit drv, input int len, input logic [63:0] d);
    for (int i = -6; i < len + 2; i++)
    begin
      fs_q[rxl] = (i == 0);
      // Released line toggles so a stale bit cannot pass as data
      if (drv)
        rx_sd = (i >= 0 && i < len) ? d[63-i] : ~rx_sd;
      #7.5;
      clk_q[rxl] = 1'b1;
      #7.5;
      clk_q[rxl] = 1'b0;
      if (!rxl && tx_sd_oe_n === 1'b0)
      begin
        got = {got[62:0], tx_sd_o};
        nbits++;
      end
    end
  endtask : lane

  task automatic frame(input bit sync, input int len, input logic [63:0] d);
    got = '0;
    nbits = 0;
    if (sync)
      lane(1'b0, 1'b1, len, d);
    else
      fork
        lane(1'b0, 1'b0, len, d);
        begin
          #3;
          lane(1'b1, 1'b1, len, d);
        end
      join
  endtask : frame
endmodule : asp_far_end

// *** verification/tb_top.sv ***
// Self-checking testbench of the audio serial port
`timescale 1ns/10ps

module tb_top;
  import asp_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_enable = 1'b0;
  logic cfg_sync_mode = 1'b0;
  logic cfg_network = 1'b0;
  logic cfg_word16 = 1'b0;
  logic [1:0] cfg_slots_m1 = 2'h0;
  logic [15:0] tx_word = 16'h0000;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  wire tx_sclk, rx_sclk, tx_fs, rx_fs, rx_sd, tx_sd_o, tx_sd_oe_n;
  wire tx_ready, tx_dma_req, rx_valid, rx_dma_req, rx_overrun;
  wire [15:0] rx_word;
  int failures = 0;
  int total_checks = 0;
  int a;
  int pops = 0;
  bit ovr_seen = 1'b0;

  always #4 ref_clk = ~ref_clk;

  asp_port i_asp_port (.ref_clk(ref_clk), .rst(rst), .tx_sclk(tx_sclk), .rx_sclk(rx_sclk),
    .cfg_enable(cfg_enable), .cfg_sync_mode(cfg_sync_mode), .cfg_network(cfg_network),
    .cfg_word16(cfg_word16), .cfg_slots_m1(cfg_slots_m1), .tx_fs(tx_fs), .tx_sd_o(tx_sd_o),
    .tx_sd_oe_n(tx_sd_oe_n), .rx_fs(rx_fs), .rx_sd(rx_sd), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_dma_req(tx_dma_req), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_dma_req(rx_dma_req),
    .rx_overrun(rx_overrun));
  asp_far_end i_asp_far_end (.tx_sclk(tx_sclk), .rx_sclk(rx_sclk), .tx_fs(tx_fs),
    .rx_fs(rx_fs), .rx_sd(rx_sd), .tx_sd_o(tx_sd_o), .tx_sd_oe_n(tx_sd_oe_n));

  // Sampled mid-cycle, away from the launching edge
  always @(negedge ref_clk)
  begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      pops++;
    if (rx_overrun === 1'b1)
      ovr_seen = 1'b1;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic cfg(input logic s, input logic n, input logic w, input logic [1:0] m);
    @(posedge ref_clk);
    cfg_enable <= 1'b0;
    @(posedge ref_clk);
    cfg_sync_mode <= s;
    cfg_network <= n;
    cfg_word16 <= w;
    cfg_slots_m1 <= m;
    @(posedge ref_clk);
    cfg_enable <= 1'b1;
  endtask : cfg

  task automatic push(input int n, input logic [15:0] base, output int acc);
    logic r;
    acc = 0;
    @(posedge ref_clk);
    tx_word <= base;
    tx_valid <= 1'b1;
    while (acc < n)
    begin
      @(negedge ref_clk);
      r = tx_ready;
      @(posedge ref_clk);
      if (r !== 1'b1)
        break;
      acc++;
      tx_word <= base + 16'(acc);
    end
    tx_valid <= 1'b0;
  endtask : push

  task automatic take(input logic [15:0] exp);
    int k;
    @(posedge ref_clk);
    rx_ready <= 1'b1;
    for (k = 0; k < 400; k++)
    begin
      @(negedge ref_clk);
      if (rx_valid === 1'b1)
        break;
    end
    chk("rx_word", exp, rx_word);
    @(posedge ref_clk);
    rx_ready <= 1'b0;
    if (k == 400)
    begin
      failures++;
      $display("unexpected rx_valid: expected 1 seen 0 after 400 cycles");
      conclude();
    end
  endtask : take

  // ==========================================================
  // Scenarios
  task automatic s_normal8();
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    push(1, 16'hff5a, a);
    i_asp_far_end.frame(1'b0, 8, {8'h3c, 56'h0});
    chk("tx byte", 8'h5a, i_asp_far_end.got);
    chk("tx bit count", 8, i_asp_far_end.nbits);
    take(16'h003c);
    i_asp_far_end.frame(1'b0, 8, {8'hc3, 56'h0});
    chk("empty slot bits", 0, i_asp_far_end.nbits);
    take(16'h00c3);
  endtask : s_normal8

  task automatic s_network16();
    cfg(1'b1, 1'b1, 1'b1, 2'h3);
    push(4, 16'h8101, a);
    i_asp_far_end.frame(1'b1, 64, 64'h1234_5678_9abc_def0);
    chk("tx frame", 64'h8101_8102_8103_8104, i_asp_far_end.got);
    take(16'h1234);
    take(16'h5678);
    take(16'h9abc);
    take(16'hdef0);
  endtask : s_network16

  task automatic s_net8();
    cfg(1'b0, 1'b1, 1'b0, 2'h1);
    push(2, 16'h0011, a);
    i_asp_far_end.frame(1'b0, 32, 64'ha1b2_c3d4_0000_0000);
    chk("tx slots", 16'h1112, i_asp_far_end.got);
    chk("tx bit count", 16, i_asp_far_end.nbits);
    take(16'h00a1);
    take(16'h00b2);
    repeat (20) @(posedge ref_clk);
    chk("rx past last slot", 1'b0, rx_valid);
    @(posedge ref_clk);
    cfg_enable <= 1'b0;
    i_asp_far_end.frame(1'b0, 8, {8'h77, 56'h0});
    repeat (20) @(posedge ref_clk);
    chk("rx while disabled", 1'b0, rx_valid);
  endtask : s_net8

  task automatic s_fill();
    cfg(1'b0, 1'b1, 1'b1, 2'h3);
    push(20, 16'h4000, a);
    chk("tx refused", 1'b1, a >= ASP_FIFO_DEPTH);
    chk("tx_dma_req full", 1'b0, tx_dma_req);
    repeat (3) i_asp_far_end.frame(1'b0, 64, 64'h0102_0304_0506_0708);
    chk("rx overrun", 1'b1, ovr_seen);
    chk("rx_dma_req", 1'b1, rx_dma_req);
    chk("tx drained", 1'b1, tx_ready);
    pops = 0;
    @(posedge ref_clk);
    rx_ready <= 1'b1;
    repeat (40) @(posedge ref_clk);
    rx_ready <= 1'b0;
    chk("rx drained", 1'b0, rx_valid);
    chk("rx held words", 1'b1, pops >= ASP_FIFO_DEPTH);
  endtask : s_fill

  // Mid-run reset with a full transmit FIFO; queued words must be gone
  task automatic s_reset();
    push(20, 16'h5000, a);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("tx_ready in reset", 1'b1, tx_ready);
    chk("rx_valid in reset", 1'b0, rx_valid);
    chk("rx_word in reset", 16'h0000, rx_word);
    chk("tx_sd_oe_n in reset", 1'b1, tx_sd_oe_n);
    rst <= 1'b0;
    i_asp_far_end.frame(1'b0, 16, 64'h0);
    chk("tx bits after reset", 0, i_asp_far_end.nbits);
    take(16'h0000);
  endtask : s_reset

  initial
  begin
    fork
      i_asp_far_end.frame(1'b0, 0, 64'h0);
      begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
      end
    join
    s_normal8();
    s_network16();
    s_net8();
    s_fill();
    s_reset();
    conclude();
  end
endmodule : tb_top
